//--- pkg/adc_seq_pkg.sv
/*
  Shared constants and carrier types for the routine sequencer, its
  converter engine and its trigger edge detector.
  Assumes one clock domain (clk_sys) and an APB register bus.
*/
package adc_seq_pkg;

  ////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFF_CTL0 = 8'h00;
  localparam logic [7:0] OFF_CTL1 = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0C;
  localparam logic [7:0] OFF_SEQ_A = 8'h10;
  localparam logic [7:0] OFF_SEQ_B = 8'h14;
  localparam logic [7:0] OFF_SEQ_C = 8'h18;

  localparam int CTL0_IRQ_EN_BIT = 5;
  localparam int CTL0_SCAN_BIT = 8;
  localparam int CTL0_PART_BIT = 11;
  localparam int CTL0_GROUP_LSB = 13;
  localparam int CTL1_ON_BIT = 0;
  localparam int CTL1_REPEAT_BIT = 1;
  localparam int CTL1_CAL_BIT = 2;
  localparam int CTL1_CALCLR_BIT = 3;
  localparam int CTL1_DMA_BIT = 8;
  localparam int CTL1_ETSEL_LSB = 17;
  localparam int CTL1_ETEN_BIT = 20;
  localparam int CTL1_SOFT_BIT = 22;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_BUSY_BIT = 4;
  localparam int SEQ_LEN_LSB = 20;

  ////////////////////////////////////////////////////////////////////////
  localparam int SLOTS = 16;
  localparam int SLOTS_PER_WORD = 6;
  localparam int CH_W = 5;
  localparam int DATA_W = 12;
  localparam int TRIG_N = 8;
  localparam int CONV_CYCLES = 14;
  localparam int CAL_CYCLES_DEFAULT = 16;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CAL = 3'b010,
    ST_CONV = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic irq_en;
    logic scan;
    logic part;
    logic [2:0] group;
    logic on;
    logic repeat_en;
    logic dma;
    logic [2:0] et_sel;
    logic et_en;
  } cfg_s;

  typedef struct packed {
    logic enable;
    logic cal_go;
    logic cal_clr;
    logic conv_go;
    logic [CH_W-1:0] chan;
  } conv_req_s;

  typedef struct packed {
    logic cal_busy;
    logic conv_done;
    logic [DATA_W-1:0] result;
  } conv_rsp_s;

endpackage

//--- verilog/trigger_edge.sv
/*
  Selects one external trigger line and emits a one-cycle pulse on its
  rising edge. Assumes the trigger lines are synchronous to clk_sys.
*/
`timescale 1ns/10ps
`default_nettype none

module trigger_edge #(
  parameter int N = adc_seq_pkg::TRIG_N
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [N-1:0] triggers,
  input wire logic [2:0] select,
  output logic pulse
);

  typedef struct packed {
    logic prev;
    logic pulse;
  } edge_s;

  edge_s s;
  edge_s next_s;

  // Changing the select may show a false edge; reprogram while idle
  always_comb begin
    next_s = s;
    next_s.prev = triggers[select];
    next_s.pulse = triggers[select] & ~s.prev;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign pulse = s.pulse;

endmodule
`default_nettype wire

//--- verilog/sar_engine.sv
/*
  Conversion timing engine: runs calibration and single conversions and
  keeps the calibration factor. Assumes the analog part presents its code
  on analog_code, and its offset code while calibrating.
*/
`timescale 1ns/10ps
`default_nettype none

module sar_engine #(
  parameter int CAL_CYCLES = adc_seq_pkg::CAL_CYCLES_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire adc_seq_pkg::conv_req_s req,
  input wire logic [adc_seq_pkg::DATA_W-1:0] analog_code,
  output adc_seq_pkg::conv_rsp_s rsp,
  output logic [adc_seq_pkg::CH_W-1:0] mux_select
);

  typedef struct packed {
    logic cal_busy;
    logic conv_busy;
    logic [15:0] cnt;
    logic [adc_seq_pkg::DATA_W-1:0] factor;
    logic done;
    logic [adc_seq_pkg::DATA_W-1:0] result;
    logic [adc_seq_pkg::CH_W-1:0] sel;
  } eng_s;

  eng_s s;
  eng_s next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (!req.enable) begin
      next_s = '0;
    end else begin
      if (req.cal_clr) begin
        next_s.factor = '0;
      end
      if (s.cal_busy || s.conv_busy) begin
        if (s.cnt == 16'h0000) begin
          next_s.cal_busy = 1'b0;
          next_s.conv_busy = 1'b0;
          if (s.cal_busy) begin
            next_s.factor = analog_code;
          end else begin
            // Offset removal saturates at zero rather than wrapping
            next_s.result = (analog_code > s.factor) ? analog_code - s.factor : '0;
            next_s.done = 1'b1;
          end
        end else begin
          next_s.cnt = 16'(s.cnt - 16'h0001);
        end
      end else if (req.cal_go) begin
        next_s.cal_busy = 1'b1;
        next_s.cnt = 16'(CAL_CYCLES - 1);
      end else if (req.conv_go) begin
        next_s.conv_busy = 1'b1;
        next_s.sel = req.chan;
        next_s.cnt = 16'(adc_seq_pkg::CONV_CYCLES - 1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rsp.cal_busy = s.cal_busy;
  assign rsp.conv_done = s.done;
  assign rsp.result = s.result;
  assign mux_select = s.sel;

endmodule
`default_nettype wire

//--- verilog/adc_routine_sequencer.sv
/*
  Routine sequencer of a 12-bit converter with APB registers: calibration
  control, enable, 16-slot sequence, single/repeat/scan/partial modes,
  triggers, done flag, interrupt level and DMA request.
  Assumes clk_sys is the converter clock, synchronous to the bus clocks,
  and that software keeps its own procedural obligations.
*/
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////
// Functional notes
// - cal_start launches calibration, self-clears when finished
// - calibration factor applied until converter powered off
// - cal_state_clear wipes stored calibration factor
// - converter_on low resets logic, powers analog down
// - converter clock is synchronous bus clock
// - sixteen slots of 5-bit channels, length field
// - single mode converts first slot once per trigger
// - completion stores result, sets done, raises interrupt
// - done flag cleared by writing zero
// - repeat keeps reconverting first slot after trigger
// - soft trigger or enabled external trigger starts
// - scan converts all entries, done after sequence
// - scan plus repeat restarts sequence automatically
// - partial mode converts next group per trigger
// - partial mode flags done once per pass
// - DMA request at end of each conversion
// - external trigger acts on rising edge
module adc_routine_sequencer #(
  parameter int CAL_CYCLES = adc_seq_pkg::CAL_CYCLES_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [adc_seq_pkg::TRIG_N-1:0] ext_triggers,
  input wire logic [adc_seq_pkg::DATA_W-1:0] analog_code,
  output logic [adc_seq_pkg::CH_W-1:0] mux_select,
  output logic analog_power_down,
  output logic dma_req,
  output logic conversion_done_irq
);

  typedef struct packed {
    adc_seq_pkg::seq_state_e st;
    adc_seq_pkg::cfg_s cfg;
    logic [adc_seq_pkg::SLOTS-1:0][adc_seq_pkg::CH_W-1:0] slot;
    logic [3:0] len;
    logic [3:0] idx;
    logic [2:0] grp;
    logic soft_pend;
    logic done;
    logic [adc_seq_pkg::DATA_W-1:0] result;
    logic dma_req;
    logic irq;
    logic pdown;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic cal_go;
    logic cal_clr;
    logic conv_go;
    logic [adc_seq_pkg::CH_W-1:0] chan;
  } top_s;

  top_s s;
  top_s next_s;
  adc_seq_pkg::conv_req_s req;
  adc_seq_pkg::conv_rsp_s rsp;
  logic ext_pulse;

  ////////////////////////////////////////////////////////////////////////
  trigger_edge #(
    .N(adc_seq_pkg::TRIG_N)
  ) u_trig (
    .clk_sys(clk_sys),
    .rst(rst),
    .triggers(ext_triggers),
    .select(s.cfg.et_sel),
    .pulse(ext_pulse)
  );

  assign req.enable = s.cfg.on;
  assign req.cal_go = s.cal_go;
  assign req.cal_clr = s.cal_clr;
  assign req.conv_go = s.conv_go;
  assign req.chan = s.chan;

  sar_engine #(
    .CAL_CYCLES(CAL_CYCLES)
  ) u_eng (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(req),
    .analog_code(analog_code),
    .rsp(rsp),
    .mux_select(mux_select)
  );

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic setup;
    logic wr;
    logic clr_done;
    logic set_done;
    logic soft_set;
    logic cal_req;
    logic trig;
    logic start;
    logic pass_end;
    logic cont;
    logic [3:0] start_idx;
    logic [3:0] next_idx;
    logic [31:0] rd;
    logic [7:0] word_off;

    setup = psel & ~penable;
    wr = psel & penable & pwrite & s.pready;
    clr_done = 1'b0;
    set_done = 1'b0;
    soft_set = 1'b0;
    cal_req = 1'b0;
    trig = 1'b0;
    start = 1'b0;
    pass_end = 1'b0;
    cont = 1'b0;
    start_idx = 4'h0;
    next_idx = 4'h0;
    rd = adc_seq_pkg::RESET_WORD;
    word_off = 8'h00;
    next_s = s;
    next_s.pready = 1'b0;
    next_s.pslverr = 1'b0;
    next_s.cal_go = 1'b0;
    next_s.cal_clr = 1'b0;
    next_s.conv_go = 1'b0;
    next_s.dma_req = 1'b0;

    // Read data is captured in the setup cycle, so access never waits
    if (setup) begin
      next_s.pready = 1'b1;
      case (paddr)
        adc_seq_pkg::OFF_CTL0: begin
          rd[adc_seq_pkg::CTL0_IRQ_EN_BIT] = s.cfg.irq_en;
          rd[adc_seq_pkg::CTL0_SCAN_BIT] = s.cfg.scan;
          rd[adc_seq_pkg::CTL0_PART_BIT] = s.cfg.part;
          rd[adc_seq_pkg::CTL0_GROUP_LSB +: 3] = s.cfg.group;
        end

        adc_seq_pkg::OFF_CTL1: begin
          rd[adc_seq_pkg::CTL1_ON_BIT] = s.cfg.on;
          rd[adc_seq_pkg::CTL1_REPEAT_BIT] = s.cfg.repeat_en;
          rd[adc_seq_pkg::CTL1_CAL_BIT] = (s.st == adc_seq_pkg::ST_CAL);
          rd[adc_seq_pkg::CTL1_DMA_BIT] = s.cfg.dma;
          rd[adc_seq_pkg::CTL1_ETSEL_LSB +: 3] = s.cfg.et_sel;
          rd[adc_seq_pkg::CTL1_ETEN_BIT] = s.cfg.et_en;
          rd[adc_seq_pkg::CTL1_SOFT_BIT] = s.soft_pend;
        end

        adc_seq_pkg::OFF_STAT: begin
          rd[adc_seq_pkg::STAT_DONE_BIT] = s.done;
          rd[adc_seq_pkg::STAT_BUSY_BIT] = (s.st != adc_seq_pkg::ST_IDLE);
        end

        adc_seq_pkg::OFF_RDATA: begin
          rd[adc_seq_pkg::DATA_W-1:0] = s.result;
        end

        adc_seq_pkg::OFF_SEQ_A, adc_seq_pkg::OFF_SEQ_B, adc_seq_pkg::OFF_SEQ_C: begin
          for (int k = 0; k < adc_seq_pkg::SLOTS; k++) begin
            word_off = 8'(adc_seq_pkg::OFF_SEQ_A + 4 * (k / adc_seq_pkg::SLOTS_PER_WORD));
            if (paddr == word_off) begin
              rd[adc_seq_pkg::CH_W * (k % adc_seq_pkg::SLOTS_PER_WORD) +: adc_seq_pkg::CH_W] = s.slot[k];
            end
          end
          if (paddr == adc_seq_pkg::OFF_SEQ_C) begin
            rd[adc_seq_pkg::SEQ_LEN_LSB +: 4] = s.len;
          end
        end

        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
      next_s.prdata = rd;
    end

    ////////////////////////////////////////////////////////////////////
    if (wr) begin
      case (paddr)
        adc_seq_pkg::OFF_CTL0: begin
          next_s.cfg.irq_en = pwdata[adc_seq_pkg::CTL0_IRQ_EN_BIT];
          next_s.cfg.scan = pwdata[adc_seq_pkg::CTL0_SCAN_BIT];
          next_s.cfg.part = pwdata[adc_seq_pkg::CTL0_PART_BIT];
          next_s.cfg.group = pwdata[adc_seq_pkg::CTL0_GROUP_LSB +: 3];
        end

        adc_seq_pkg::OFF_CTL1: begin
          next_s.cfg.on = pwdata[adc_seq_pkg::CTL1_ON_BIT];
          next_s.cfg.repeat_en = pwdata[adc_seq_pkg::CTL1_REPEAT_BIT];
          next_s.cfg.dma = pwdata[adc_seq_pkg::CTL1_DMA_BIT];
          next_s.cfg.et_sel = pwdata[adc_seq_pkg::CTL1_ETSEL_LSB +: 3];
          next_s.cfg.et_en = pwdata[adc_seq_pkg::CTL1_ETEN_BIT];
          cal_req = pwdata[adc_seq_pkg::CTL1_CAL_BIT];
          next_s.cal_clr = pwdata[adc_seq_pkg::CTL1_CALCLR_BIT];
          soft_set = pwdata[adc_seq_pkg::CTL1_SOFT_BIT];
        end

        adc_seq_pkg::OFF_STAT: begin
          clr_done = ~pwdata[adc_seq_pkg::STAT_DONE_BIT];
        end

        adc_seq_pkg::OFF_SEQ_A, adc_seq_pkg::OFF_SEQ_B, adc_seq_pkg::OFF_SEQ_C: begin
          for (int k = 0; k < adc_seq_pkg::SLOTS; k++) begin
            word_off = 8'(adc_seq_pkg::OFF_SEQ_A + 4 * (k / adc_seq_pkg::SLOTS_PER_WORD));
            if (paddr == word_off) begin
              next_s.slot[k] = pwdata[adc_seq_pkg::CH_W * (k % adc_seq_pkg::SLOTS_PER_WORD) +: adc_seq_pkg::CH_W];
            end
          end
          if (paddr == adc_seq_pkg::OFF_SEQ_C) begin
            next_s.len = pwdata[adc_seq_pkg::SEQ_LEN_LSB +: 4];
          end
        end

        default: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////
    // An edge seen while busy is lost; a soft request stays pending
    trig = s.soft_pend | (ext_pulse & s.cfg.et_en);
    start_idx = (s.cfg.scan | s.cfg.part) ? s.idx : 4'h0;

    if (!s.cfg.on) begin
      // Held in reset; calibration factor is lost in the engine too
      next_s.st = adc_seq_pkg::ST_IDLE;
      next_s.idx = 4'h0;
      next_s.grp = 3'h0;
      next_s.soft_pend = 1'b0;
      soft_set = 1'b0;
      // The done flag is conversion state too, so it drops while off
      clr_done = 1'b1;
    end else begin
      case (s.st)
        adc_seq_pkg::ST_IDLE: begin
          // Calibration wins over a trigger that arrives with it
          if (cal_req) begin
            next_s.st = adc_seq_pkg::ST_CAL;
            next_s.cal_go = 1'b1;
          end else if (trig) begin
            start = 1'b1;
            next_s.st = adc_seq_pkg::ST_CONV;
            next_s.chan = s.slot[start_idx];
            next_s.conv_go = 1'b1;
            next_s.grp = s.cfg.group;
          end
        end

        adc_seq_pkg::ST_CAL: begin
          // cal_go is still in flight in its first cycle, before busy rises
          if (!rsp.cal_busy && !s.cal_go) begin
            next_s.st = adc_seq_pkg::ST_IDLE;
          end
        end

        adc_seq_pkg::ST_CONV: begin
          if (rsp.conv_done) begin
            next_s.result = rsp.result;
            next_s.dma_req = s.cfg.dma;
            // Partial mode beats scan, and ignores repeat
            pass_end = ~(s.cfg.scan | s.cfg.part) | (s.idx == s.len);
            set_done = pass_end;
            next_idx = pass_end ? 4'h0 : 4'(s.idx + 4'h1);
            if (s.cfg.part) begin
              cont = ~pass_end & (s.grp != 3'h0);
              next_s.grp = 3'(s.grp - 3'h1);
            end else if (s.cfg.scan) begin
              cont = ~pass_end | s.cfg.repeat_en;
            end else begin
              cont = s.cfg.repeat_en;
            end
            next_s.idx = next_idx;
            if (cont) begin
              next_s.chan = s.slot[next_idx];
              next_s.conv_go = 1'b1;
            end else begin
              next_s.st = adc_seq_pkg::ST_IDLE;
            end
          end
        end

        default: begin
          next_s.st = adc_seq_pkg::ST_IDLE;
        end
      endcase
    end

    // A trigger request arriving with a start is kept, not lost
    next_s.soft_pend = (next_s.soft_pend & ~start) | soft_set;
    // Hardware set wins over a software clear in the same cycle
    next_s.done = (s.done & ~clr_done) | set_done;
    // Interrupt is a level that follows the flag, not a pulse
    next_s.irq = next_s.done & next_s.cfg.irq_en;
    next_s.pdown = ~next_s.cfg.on;
  end

  // Bus and converter share clk_sys, so nothing crosses a domain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s <= '0;
      s.st <= adc_seq_pkg::ST_IDLE;
      s.pdown <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign analog_power_down = s.pdown;
  assign dma_req = s.dma_req;
  assign conversion_done_irq = s.irq;

endmodule
`default_nettype wire

//--- verif/adc_seq_checker_assertions.sv
/*
  Port checker for the routine sequencer, bound to every instance.
  Assumes one clock domain and zero-wait APB answers.
*/
`timescale 1ns/10ps
`default_nettype none
module adc_seq_checker #(
  parameter int CAL_CYCLES = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [adc_seq_pkg::CH_W-1:0] mux_select,
  input wire logic analog_power_down,
  input wire logic dma_req,
  input wire logic conversion_done_irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic wr_done;
  assign wr_done = pready && pwrite;
  ////////////////////////////////////////
  property p_ready_next;
    psel && !penable |=> pready;
  endproperty
  a_ready_next: assert property (p_ready_next) else $error("no ready after setup");
  property p_ready_access;
    pready |-> psel && penable && $past(psel && !penable);
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("ready outside first access");
  property p_err_unmapped;
    psel && !penable && paddr > adc_seq_pkg::OFF_SEQ_C |=> pslverr;
  endproperty
  a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access accepted");
  property p_err_mapped;
    pslverr |-> pready && ($past(paddr) > adc_seq_pkg::OFF_SEQ_C || ($past(paddr) & 8'h03) != 8'h00);
  endproperty
  a_err_mapped: assert property (p_err_mapped) else $error("error on mapped access");
  ////////////////////////////////////////
  property p_off_quiet;
    analog_power_down && $past(analog_power_down) |-> mux_select == '0 && !dma_req && !conversion_done_irq;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("activity while off");
  property p_off_cause;
    $rose(analog_power_down) |-> $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_off_cause: assert property (p_off_cause) else $error("power down without write");
  // A conversion takes 14 cycles, so requests can never come within 8 cycles of each other
  property p_dma_gap;
    dma_req |=> (!dma_req) [*8];
  endproperty
  a_dma_gap: assert property (p_dma_gap) else $error("dma requests too close");
  property p_irq_clear;
    $fell(conversion_done_irq) |-> $past(wr_done) || $past(wr_done, 2) || analog_power_down;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("irq dropped by itself");
  property p_irq_on;
    $rose(conversion_done_irq) |-> !analog_power_down;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq while powered down");
endmodule
bind adc_routine_sequencer adc_seq_checker #(.CAL_CYCLES(CAL_CYCLES)) i_adc_seq_checker (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .mux_select(mux_select), .analog_power_down(analog_power_down),
  .dma_req(dma_req), .conversion_done_irq(conversion_done_irq));
`default_nettype wire

//--- verif/analog_model.sv
/*
  Analog front end model: code = base + 16 * channel, one cycle late.
  Assumes the bench sets base; no stable code while powered down.
*/
`timescale 1ns/10ps
`default_nettype none
module analog_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [adc_seq_pkg::CH_W-1:0] mux_select,
  input wire logic analog_power_down,
  input wire logic [11:0] base,
  output logic [11:0] analog_code
);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      analog_code <= 12'h5A5;
    end else if (analog_power_down) begin
      // Toggling so a stale code can never look valid
      analog_code <= ~analog_code;
    end else begin
      analog_code <= base + {3'h0, mux_select, 4'h0};
    end
  end
endmodule
`default_nettype wire

//--- verif/tb.sv
/*
  Self-checking bench: APB master tasks and one task per scenario.
  Assumes analog_model on the analog side; DMA is a request counter.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
  localparam logic [31:0] ON = 32'h1 << adc_seq_pkg::CTL1_ON_BIT;
  localparam logic [31:0] REP = 32'h1 << adc_seq_pkg::CTL1_REPEAT_BIT;
  localparam logic [31:0] CAL = 32'h1 << adc_seq_pkg::CTL1_CAL_BIT;
  localparam logic [31:0] CLR = 32'h1 << adc_seq_pkg::CTL1_CALCLR_BIT;
  localparam logic [31:0] DMA = 32'h1 << adc_seq_pkg::CTL1_DMA_BIT;
  localparam logic [31:0] SOFT = 32'h1 << adc_seq_pkg::CTL1_SOFT_BIT;
  localparam logic [31:0] SCAN = 32'h1 << adc_seq_pkg::CTL0_SCAN_BIT;
  localparam logic [7:0] C0 = adc_seq_pkg::OFF_CTL0;
  localparam logic [7:0] C1 = adc_seq_pkg::OFF_CTL1;
  localparam logic [7:0] ST = adc_seq_pkg::OFF_STAT;
  localparam logic [7:0] RD = adc_seq_pkg::OFF_RDATA;
  localparam logic [7:0] SA = adc_seq_pkg::OFF_SEQ_A;
  localparam logic [7:0] SC = adc_seq_pkg::OFF_SEQ_C;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err, pd, dma_req, irq, ien;
  logic [7:0] paddr, ext;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] code, base, fac;
  logic [4:0] mux;
  int error_cnt = 0;
  int total_checks = 0;
  int dma_cnt = 0;
  adc_routine_sequencer #(.CAL_CYCLES(8)) i_adc_routine_sequencer (
    .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_triggers(ext),
    .analog_code(code), .mux_select(mux), .analog_power_down(pd), .dma_req(dma_req),
    .conversion_done_irq(irq));
  analog_model i_analog_model (.clk_sys(clk_sys), .rst(rst), .mux_select(mux),
    .analog_power_down(pd), .base(base), .analog_code(code));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (dma_req === 1'b1) begin
      dma_cnt <= dma_cnt + 1;
    end
  end
  ////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad(m);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      bad("no ready");
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // Exact mode idles 40 cycles afterwards so a surplus conversion shows
  task automatic wait_dma(input int n, input logic ex);
    for (int i = 0; i < 800 && dma_cnt < n; i++) begin
      @(posedge clk_sys);
    end
    if (dma_cnt < n) begin
      bad("dma wait");
      results();
    end
    if (ex) begin
      repeat (40) @(posedge clk_sys);
      chk(dma_cnt, n, "dma count");
    end
  endtask
  task automatic conv(input logic [31:0] ctl, input int n, input logic [4:0] ch, input logic dn);
    wr(C1, ctl | SOFT);
    wait_dma(dma_cnt + n, 1'b1);
    xfer(1'b0, ST, 32'h0);
    chk(rd[adc_seq_pkg::STAT_DONE_BIT], dn, "done flag");
    if (dn) begin
      chk(irq, ien, "irq level");
      xfer(1'b0, RD, 32'h0);
      chk(rd, {20'h0, base + {3'h0, ch, 4'h0} - fac}, "result");
      wr(ST, 32'h0);
      xfer(1'b0, ST, 32'h0);
      chk({rd[adc_seq_pkg::STAT_DONE_BIT], irq}, 2'h0, "done clear");
    end
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    for (int k = 0; k < 7; k++) begin
      xfer(1'b0, 8'(4 * k), 32'h0);
      chk(rd, adc_seq_pkg::RESET_WORD, "reset value");
    end
    chk({pd, mux}, 6'h20, "idle outputs");
    wr(8'h1C, 32'hFFFF_FFFF);
    chk(err, 1'b1, "unmapped write");
    xfer(1'b0, 8'h1C, 32'h0);
    chk(err, 1'b1, "unmapped read");
    $display("reset test done");
  endtask
  task automatic calib(input logic [11:0] off);
    base <= off;
    wr(C1, ON | CAL);
    xfer(1'b0, C1, 32'h0);
    chk(rd[adc_seq_pkg::CTL1_CAL_BIT], 1'b1, "cal busy");
    for (int i = 0; i < 30 && rd[adc_seq_pkg::CTL1_CAL_BIT] !== 1'b0; i++) begin
      xfer(1'b0, C1, 32'h0);
    end
    chk(rd[adc_seq_pkg::CTL1_CAL_BIT], 1'b0, "cal end");
    base <= 12'h100;
    fac = off;
  endtask
  task automatic t_cal();
    wr(C1, ON);
    repeat (14) @(posedge clk_sys);
    chk(pd, 1'b0, "powered");
    calib(12'h020);
    conv(ON | DMA, 1, 5'h0, 1'b1);
    wr(C1, ON | CLR);
    fac = 12'h000;
    conv(ON | DMA, 1, 5'h0, 1'b1);
    calib(12'h030);
    conv(ON | DMA, 1, 5'h0, 1'b1);
    $display("calibration test done");
  endtask
  task automatic t_single();
    int d0;
    wr(SA, 32'h5);
    ien = 1'b1;
    wr(C0, 32'h1 << adc_seq_pkg::CTL0_IRQ_EN_BIT);
    conv(ON | DMA, 1, 5'h5, 1'b1);
    d0 = dma_cnt;
    wr(C1, ON | DMA | (32'h1 << adc_seq_pkg::CTL1_ETEN_BIT) | (32'h3 << adc_seq_pkg::CTL1_ETSEL_LSB));
    ext <= 8'h04;
    repeat (30) @(posedge clk_sys);
    chk(dma_cnt, d0, "unselected line");
    ext <= 8'h0C;
    wait_dma(d0 + 1, 1'b1);
    ext <= 8'h00;
    wr(ST, 32'h0);
    ien = 1'b0;
    $display("single test done");
  endtask
  task automatic t_seq();
    wr(C0, SCAN);
    wr(SA, 32'h0000_0C41);
    wr(SC, 32'h00F8_8000);
    conv(ON | DMA, 16, 5'h11, 1'b1);
    wr(C0, (32'h1 << adc_seq_pkg::CTL0_PART_BIT) | (32'h1 << adc_seq_pkg::CTL0_GROUP_LSB));
    wr(SA, 32'h0052_0C41);
    wr(SC, 32'h0040_0000);
    conv(ON | DMA, 2, 5'h0, 1'b0);
    conv(ON | DMA, 2, 5'h0, 1'b0);
    conv(ON | DMA, 1, 5'h5, 1'b1);
    $display("sequence test done");
  endtask
  task automatic t_repeat();
    int d0;
    wr(C0, SCAN);
    wr(C1, ON | DMA | REP | SOFT);
    wait_dma(dma_cnt + 8, 1'b0);
    xfer(1'b0, ST, 32'h0);
    chk(rd[adc_seq_pkg::STAT_DONE_BIT], 1'b1, "pass done");
    wr(C1, 32'h0);
    // A pulse launched at the power-off edge is counted one edge later
    @(posedge clk_sys);
    d0 = dma_cnt;
    repeat (40) @(posedge clk_sys);
    chk({pd, 32'(dma_cnt)}, {1'b1, 32'(d0)}, "stopped");
    wr(C1, ON);
    repeat (14) @(posedge clk_sys);
    wr(C0, 32'h0);
    wr(C1, ON | DMA | REP | SOFT);
    wait_dma(dma_cnt + 3, 1'b0);
    xfer(1'b0, RD, 32'h0);
    chk(rd, {20'h0, base + {3'h0, 5'h01, 4'h0}}, "repeat result");
    wr(C1, 32'h0);
    $display("repeat test done");
  endtask
  ////////////////////////////////////////
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext = 8'h00;
    base = 12'h100;
    fac = 12'h000;
    ien = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_reset();
    t_cal();
    t_single();
    t_seq();
    t_repeat();
    results();
  end
endmodule
`default_nettype wire
